// file: logic/light_pkg.sv
// Purpose: Shared constants and types for the ambient light config/result block
// Assumes: 8-bit register port fed by the serial slave engine on the same clock
// Notes:   Parameter register reset value is built from its field defaults
package light_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_PARAMS      = 8'h84;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h85;
    localparam logic [7:0] ADDR_RESULT_LOW  = 8'h86;

    // ----------------------------------------------------------------
    // Parameter register fields
    // ----------------------------------------------------------------
    localparam int BIT_CONT      = 7;
    localparam int RATE_MSB      = 6;
    localparam int RATE_LSB      = 4;
    localparam int BIT_OFFSET    = 3;
    localparam int AVG_MSB       = 2;
    localparam int AVG_LSB       = 0;
    localparam logic       RST_CONT   = 1'h0;
    localparam logic [2:0] RST_RATE   = 3'h1;
    localparam logic       RST_OFFSET = 1'h1;
    localparam logic [2:0] RST_AVG    = 3'h5;
    localparam logic [7:0] RST_PARAMS = {RST_CONT, RST_RATE, RST_OFFSET, RST_AVG};
    localparam logic [2:0] RATE_MAX   = 3'h5;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLOCK_HZ   = 40_000_000;
    localparam int CNT_W      = 26;
    localparam int ACC_W      = 23;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_OFFSET = 2'b01,
        ST_CONV   = 2'b10,
        ST_DONE   = 2'b11
    } meas_state_e;

    typedef struct packed {
        logic start;
        logic offset_phase;
    } conv_req_s;

endpackage

// file: logic/light_channel.sv
// Purpose: Light parameter register, measurement sequencing and result registers
// Assumes: Register port, command levels and converter are all on clock
// Notes:   Converter is external; this block sequences it and averages
`timescale 1ns/1ps

module light_channel #(
    parameter int CLK_HZ = light_pkg::CLOCK_HZ
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // Command levels
    input  wire logic        selftimed_en,
    input  wire logic        light_single_shot_request,
    // Converter
    output light_pkg::conv_req_s conv_req,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_data,
    // Status
    output logic             result_ready
);

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    logic [7:0]  params_ff, active_ff, rdata_ff;
    logic [15:0] result_ff, offset_ff;
    logic        selftimed_q_ff, run_ff, ready_ff;
    light_pkg::conv_req_s req_ff;
    light_pkg::meas_state_e state_ff, nxt_state;

    wire wr_params = reg_wr && reg_addr == light_pkg::ADDR_PARAMS;
    wire sel_high  = reg_addr == light_pkg::ADDR_RESULT_HIGH;
    wire sel_low   = reg_addr == light_pkg::ADDR_RESULT_LOW;
    wire [7:0] nxt_rdata = (reg_addr == light_pkg::ADDR_PARAMS) ? params_ff :
                           sel_high ? result_ff[15:8] :
                           sel_low  ? result_ff[7:0]  : 8'h00;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            params_ff <= light_pkg::RST_PARAMS;
        end else if (wr_params) begin
            params_ff <= reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata = rdata_ff;

    // ----------------------------------------------------------------
    // Active settings
    // ----------------------------------------------------------------
    // hold during self-timed run
    wire load_active = !selftimed_q_ff;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            active_ff      <= light_pkg::RST_PARAMS;
            selftimed_q_ff <= 1'b0;
        end else begin
            selftimed_q_ff <= selftimed_en;
            if (load_active) begin
                active_ff <= params_ff;
            end
        end
    end

    wire       cont_on = active_ff[light_pkg::BIT_CONT];
    wire [2:0] rate    = active_ff[light_pkg::RATE_MSB:light_pkg::RATE_LSB];
    wire       ofs_on  = active_ff[light_pkg::BIT_OFFSET];
    wire [2:0] avg_n   = active_ff[light_pkg::AVG_MSB:light_pkg::AVG_LSB];

    // ----------------------------------------------------------------
    // Sample rate divider
    // ----------------------------------------------------------------
    // period per code; unlisted codes clamp to the fastest rate
    wire [2:0] rate_c = (rate > light_pkg::RATE_MAX) ? light_pkg::RATE_MAX : rate;
    wire [light_pkg::CNT_W-1:0] period =
        light_pkg::CNT_W'(CLK_HZ / (int'(rate_c) + 1));
    logic [light_pkg::CNT_W-1:0] tick_cnt_ff;
    wire tick = selftimed_en && (tick_cnt_ff == period - 1'b1);

    always_ff @(posedge clock) begin
        if (!rst_n || !selftimed_en || tick) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Measurement sequencer
    // ----------------------------------------------------------------
    logic [7:0]                 cnt_ff;
    logic [light_pkg::ACC_W-1:0] acc_ff;

    wire go = selftimed_en ? tick : (light_single_shot_request || run_ff);
    wire [7:0] last_cnt = 8'((9'h001 << avg_n) - 9'h001);
    wire [15:0] sample = !ofs_on ? conv_data :
                         (conv_data > offset_ff) ? conv_data - offset_ff : 16'h0000;
    wire [light_pkg::ACC_W-1:0] acc_sum = acc_ff + light_pkg::ACC_W'(sample);
    wire [15:0] mean = 16'(acc_ff >> avg_n);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            light_pkg::ST_IDLE:   if (go) begin
                nxt_state = ofs_on ? light_pkg::ST_OFFSET : light_pkg::ST_CONV;
            end
            light_pkg::ST_OFFSET: if (conv_done) begin
                nxt_state = light_pkg::ST_CONV;
            end
            light_pkg::ST_CONV:   if (conv_done && cnt_ff == last_cnt) begin
                nxt_state = light_pkg::ST_DONE;
            end
            light_pkg::ST_DONE:   nxt_state = light_pkg::ST_IDLE;
            default:              nxt_state = light_pkg::ST_IDLE;
        endcase
    end

    wire starting = state_ff == light_pkg::ST_IDLE && go;
    wire more     = (state_ff == light_pkg::ST_OFFSET && conv_done) ||
                    (state_ff == light_pkg::ST_CONV && conv_done && cnt_ff != last_cnt);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_ff <= light_pkg::ST_IDLE;
            req_ff   <= '0;
            cnt_ff   <= 8'h00;
            acc_ff   <= '0;
            offset_ff <= 16'h0000;
        end else begin
            state_ff            <= nxt_state;
            req_ff.start        <= starting || more;
            req_ff.offset_phase <= starting && ofs_on;
            if (starting) begin
                cnt_ff <= 8'h00;
                acc_ff <= '0;
            end else if (state_ff == light_pkg::ST_OFFSET && conv_done) begin
                offset_ff <= conv_data;
            end else if (state_ff == light_pkg::ST_CONV && conv_done) begin
                cnt_ff <= cnt_ff + 8'h01;
                acc_ff <= acc_sum;
            end
        end
    end
    assign conv_req = req_ff;

    always_ff @(posedge clock) begin
        if (!rst_n || selftimed_en || !cont_on) begin
            run_ff <= 1'b0;
        end else if (light_single_shot_request) begin
            run_ff <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            result_ff <= 16'h0000;
            ready_ff  <= 1'b0;
        end else begin
            ready_ff <= state_ff == light_pkg::ST_DONE;
            if (state_ff == light_pkg::ST_DONE) begin
                result_ff <= mean;
            end
        end
    end
    assign result_ready = ready_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_reset_params;
        @(posedge clock) !rst_n |=> params_ff == light_pkg::RST_PARAMS;
    endproperty
    a_reset_params: assert property (p_reset_params) else $error("params reset wrong");

    property p_write_params;
        @(posedge clock) disable iff (!rst_n) wr_params |=> params_ff == $past(reg_wdata);
    endproperty
    a_write_params: assert property (p_write_params) else $error("params write lost");

    property p_result_ro;
        @(posedge clock) disable iff (!rst_n)
            reg_wr && (sel_high || sel_low) && state_ff != light_pkg::ST_DONE |=> $stable(result_ff);
    endproperty
    a_result_ro: assert property (p_result_ro) else $error("result changed by write");

    property p_read_high;
        @(posedge clock) disable iff (!rst_n) sel_high |=> reg_rdata == $past(result_ff[15:8]);
    endproperty
    a_read_high: assert property (p_read_high) else $error("high byte read wrong");

    property p_read_low;
        @(posedge clock) disable iff (!rst_n) sel_low |=> reg_rdata == $past(result_ff[7:0]);
    endproperty
    a_read_low: assert property (p_read_low) else $error("low byte read wrong");

    property p_hold_active;
        @(posedge clock) disable iff (!rst_n) selftimed_q_ff && selftimed_en |=> $stable(active_ff);
    endproperty
    a_hold_active: assert property (p_hold_active) else $error("settings changed mid run");

    sequence s_start_ofs;
        state_ff == light_pkg::ST_IDLE && go && ofs_on;
    endsequence
    property p_offset_first;
        @(posedge clock) disable iff (!rst_n)
            s_start_ofs |=> state_ff == light_pkg::ST_OFFSET && conv_req.offset_phase;
    endproperty
    a_offset_first: assert property (p_offset_first) else $error("no offset phase");

    property p_mean;
        @(posedge clock) disable iff (!rst_n)
            state_ff == light_pkg::ST_DONE |=> result_ff == $past(mean) && result_ready;
    endproperty
    a_mean: assert property (p_mean) else $error("result not mean");

    property p_count;
        @(posedge clock) disable iff (!rst_n)
            state_ff == light_pkg::ST_DONE |-> cnt_ff == 8'(last_cnt + 8'h01);
    endproperty
    a_count: assert property (p_count) else $error("conversion count wrong");

    sequence s_cont_done;
        state_ff == light_pkg::ST_DONE && run_ff && cont_on && !selftimed_en;
    endsequence
    property p_back_to_back;
        @(posedge clock) disable iff (!rst_n)
            s_cont_done ##1 !selftimed_en |-> ##1 state_ff != light_pkg::ST_IDLE;
    endproperty
    a_back_to_back: assert property (p_back_to_back) else $error("no back-to-back run");

endmodule

// file: tb/conv_model.sv
// Purpose: Converter stand-in answering each start with one sample
// Assumes: Same clock as the block; dly sets answer latency
// Notes:   Data lines show the inverse of the last sample when idle
`timescale 1ns/1ps
module conv_model (
    // Clock
    input  wire logic             clock,
    // Requests and shaping
    input  light_pkg::conv_req_s  conv_req,
    input  wire logic [15:0]      base,
    input  wire logic [15:0]      step,
    input  wire logic [15:0]      off,
    input  wire logic [3:0]       dly,
    // Answer
    output logic                  conv_done,
    output logic [15:0]           conv_data
);
    logic [3:0]  cnt = 4'h0;
    logic        busy = 1'b0;
    logic        ph = 1'b0;
    logic        tog = 1'b0;
    logic [15:0] last = 16'h0000;
    wire  [15:0] val = ph ? off : (tog ? base + step : base);
    // Alternating samples so the mean differs from any single one
    always @(posedge clock) begin
        conv_done <= 1'b0;
        conv_data <= ~last;
        if (conv_req.start) begin
            busy <= 1'b1;
            cnt  <= dly;
            ph   <= conv_req.offset_phase;
        end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (busy) begin
            busy      <= 1'b0;
            conv_done <= 1'b1;
            conv_data <= val;
            last      <= val;
            if (!ph) begin
                tog <= ~tog;
            end
        end
    end
endmodule

// file: tb/test_ambient_light_config_and_result.sv
// Purpose: Register and measurement checks of the light channel
// Assumes: CLK_HZ shortened to 60 so rate ticks come every few cycles
// Notes:   Host side driven here; converter is conv_model
`timescale 1ns/1ps
module test_ambient_light_config_and_result;
    logic        clock;
    logic        rst_n = 1'b0;
    logic        reg_wr = 1'b0;
    logic        req = 1'b0;
    logic        st_en = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic        conv_done;
    logic        result_ready;
    logic [15:0] conv_data;
    logic [15:0] base = 16'h0000;
    logic [15:0] step = 16'h0000;
    logic [15:0] off = 16'h0000;
    logic [3:0]  dly = 4'h0;
    light_pkg::conv_req_s conv_req;
    int fails = 0;
    int cmp_count = 0;
    int n_start = 0;
    int n_ready = 0;

    light_channel #(.CLK_HZ(60)) i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .selftimed_en(st_en), .light_single_shot_request(req), .conv_req(conv_req),
        .conv_done(conv_done), .conv_data(conv_data), .result_ready(result_ready));
    conv_model i_conv (.clock(clock), .conv_req(conv_req), .base(base), .step(step),
        .off(off), .dly(dly), .conv_done(conv_done), .conv_data(conv_data));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (conv_req.start === 1'b1) n_start++;
        if (result_ready === 1'b1) n_ready++;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        repeat (2) @(posedge clock);
        #1 chk({8'h00, reg_rdata}, {8'h00, e});
    endtask
    task automatic wait_rdy(output int c);
        c = 0;
        do begin
            @(posedge clock);
            c++;
        end while (result_ready !== 1'b1 && c < 3000);
        if (c >= 3000) chk(16'h0001, 16'h0000);
    endtask
    task automatic shot();
        @(posedge clock);
        req <= 1'b1;
        @(posedge clock);
        req <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clock);
        fails++;
        tally_and_finish();
    end

    initial begin
        int c;
        logic [15:0] e;
        logic [7:0]  p;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        rd(light_pkg::ADDR_PARAMS, 8'h1D);
        rd(light_pkg::ADDR_RESULT_HIGH, 8'h00);
        rd(light_pkg::ADDR_RESULT_LOW, 8'h00);
        rd(8'h87, 8'h00);
        // Every averaging count up to 8, offset on and off, answer delay rising from 0 to 3
        for (int n = 0; n < 4; n++) begin
            for (int o = 0; o < 2; o++) begin
                p = {4'h1, o[0], n[2:0]};
                base <= 16'h1234;
                step <= (n != 0) ? 16'h0040 : 16'h0000;
                off  <= 16'h0010;
                dly  <= n[3:0];
                wr(light_pkg::ADDR_PARAMS, p);
                rd(light_pkg::ADDR_PARAMS, p);
                e = 16'h1234 + ((n != 0) ? 16'h0020 : 16'h0000) - ((o != 0) ? 16'h0010 : 16'h0000);
                #1 n_start = 0;
                shot();
                wait_rdy(c);
                chk(16'(n_start), 16'((1 << n) + o));
                rd(light_pkg::ADDR_RESULT_HIGH, e[15:8]);
                rd(light_pkg::ADDR_RESULT_LOW, e[7:0]);
            end
        end
        // Offset above reading saturates at zero
        dly <= 4'h0;
        off <= 16'hFFFF;
        wr(light_pkg::ADDR_PARAMS, 8'h08);
        shot();
        wait_rdy(c);
        rd(light_pkg::ADDR_RESULT_LOW, 8'h00);
        wr(light_pkg::ADDR_RESULT_HIGH, 8'hFF);
        wr(light_pkg::ADDR_RESULT_LOW, 8'hFF);
        rd(light_pkg::ADDR_RESULT_HIGH, 8'h00);
        rd(light_pkg::ADDR_RESULT_LOW, 8'h00);
        // Continuous mode only with single shots, self-timed off
        wr(light_pkg::ADDR_PARAMS, 8'h80);
        #1 n_ready = 0;
        shot();
        repeat (300) @(posedge clock);
        chk(16'(n_ready >= 3), 16'h0001);
        wr(light_pkg::ADDR_PARAMS, 8'h00);
        repeat (50) @(posedge clock);
        #1 n_ready = 0;
        repeat (200) @(posedge clock);
        chk(16'(n_ready), 16'h0000);
        // Self-timed: rate code 5 gives a tick every 60/6 cycles
        wr(light_pkg::ADDR_PARAMS, 8'h50);
        @(posedge clock);
        st_en <= 1'b1;
        wait_rdy(c);
        wait_rdy(c);
        chk(16'(c), 16'h000A);
        wr(light_pkg::ADDR_PARAMS, 8'h52);
        wait_rdy(c);
        #1 n_start = 0;
        wait_rdy(c);
        chk(16'(n_start), 16'h0001);
        @(posedge clock);
        st_en <= 1'b0;
        repeat (40) @(posedge clock);
        st_en <= 1'b1;
        #1 n_start = 0;
        wait_rdy(c);
        chk(16'(n_start), 16'h0004);
        // Rate end points: slowest code, then an unlisted code clamped to the fastest
        for (int r = 0; r < 2; r++) begin
            @(posedge clock);
            st_en <= 1'b0;
            wr(light_pkg::ADDR_PARAMS, r[0] ? 8'h70 : 8'h00);
            @(posedge clock);
            st_en <= 1'b1;
            wait_rdy(c);
            wait_rdy(c);
            chk(16'(c), r[0] ? 16'h000A : 16'h003C);
        end
        tally_and_finish();
    end
endmodule
